// *** shared/bsc_pkg.sv ***
// Package of constants for the boundary-scan test access port.
// Assumes a 40 MHz system clock that oversamples the test clock.
package bsc_pkg;

   // ----------------------------------------
   // Instruction register
   // ----------------------------------------
   localparam int          IR_W          = 4;
   localparam logic [3:0]  INS_EXTEST    = 4'h0;
   localparam logic [3:0]  INS_SAMPLE    = 4'h1;
   localparam logic [3:0]  INS_IDCODE    = 4'h2;
   localparam logic [3:0]  INS_HIGHZ     = 4'h3;
   localparam logic [3:0]  INS_BYPASS    = 4'hF;
   // Fixed low bits captured in Capture-IR
   localparam logic [3:0]  IR_CAPTURE    = 4'h1;

   // ----------------------------------------
   // Identification register layout
   // ----------------------------------------
   localparam int          ID_W          = 32;
   localparam int          ID_VER_LSB    = 28;
   localparam int          ID_PART_LSB   = 12;
   localparam int          ID_MFR_LSB    = 1;
   // Values arbitrary, not a real vendor or part
   localparam logic [3:0]  ID_VERSION    = 4'h1;
   localparam logic [15:0] ID_PART       = 16'h1234;
   localparam logic [10:0] ID_MFR        = 11'h055;

   // ----------------------------------------
   // Boundary register and reset sequence
   // ----------------------------------------
   localparam int          BSR_W         = 8;
   localparam int          TMS_RESET_CNT = 5;

   typedef enum logic [3:0] {
      TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PAU_DR, TS_EX2_DR, TS_UPD_DR,
      TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
   } bsc_state_t;

endpackage

// *** design/bsc_tap.sv ***
// Boundary-scan test access port: TAP state machine, instruction,
// bypass, identification and boundary registers.
// Assumes test pins are asynchronous and the test clock is much slower
// than sys_clk, which samples it and finds its edges.
`timescale 1ns/1ps
module bsc_tap
   import bsc_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             rst_b,
   input  wire logic             tck,
   input  wire logic             tms,
   input  wire logic             tdi,
   input  wire logic             trst_b,
   output logic                  tdo,
   output logic                  tdo_oe,
   input  wire logic [BSR_W-1:0] pin_in,
   input  wire logic [BSR_W-1:0] core_out,
   output logic      [BSR_W-1:0] bsr_out,
   output logic                  test_ctl,
   output logic                  out_hiz,
   output logic                  tap_in_reset
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [1:0] tck_s_r, tms_s_r, tdi_s_r, trst_s_r;
   logic       tck_d_r;
   logic       tck_rise, tck_fall, trst_act;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tck_s_r  <= 2'h0;
         tms_s_r  <= 2'h3;
         tdi_s_r  <= 2'h3;
         trst_s_r <= 2'h3;
         tck_d_r  <= 1'b0;
      end else begin
         tck_s_r  <= {tck_s_r[0], tck};
         tms_s_r  <= {tms_s_r[0], tms};
         tdi_s_r  <= {tdi_s_r[0], tdi};
         trst_s_r <= {trst_s_r[0], trst_b};
         tck_d_r  <= tck_s_r[1];
      end
   end

   assign tck_rise = tck_s_r[1] & ~tck_d_r;
   assign tck_fall = ~tck_s_r[1] & tck_d_r;
   // Test reset, low active; unused pin held high
   assign trst_act = ~trst_s_r[1];

   // ----------------------------------------
   // State machine and registers
   // ----------------------------------------
   bsc_state_t       st_r, st_nxt;
   logic [IR_W-1:0]  ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
   logic [ID_W-1:0]  dr_sh_r, dr_sh_nxt;
   logic [BSR_W-1:0] bsr_out_r, bsr_out_nxt;
   logic             tdo_r, tdo_nxt;
   logic             sel_bsr;
   logic [ID_W-1:0]  id_word;

   assign id_word = {ID_VERSION, ID_PART, ID_MFR, 1'b1};
   assign sel_bsr = (ir_r == INS_EXTEST) || (ir_r == INS_SAMPLE);

   always_comb begin
      st_nxt      = st_r;
      ir_sh_nxt   = ir_sh_r;
      ir_nxt      = ir_r;
      dr_sh_nxt   = dr_sh_r;
      bsr_out_nxt = bsr_out_r;
      tdo_nxt     = tdo_r;
      if (tck_rise) begin
         case (st_r)
            TS_RESET:  st_nxt = tms_s_r[1] ? TS_RESET  : TS_IDLE;
            TS_IDLE:   st_nxt = tms_s_r[1] ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: st_nxt = tms_s_r[1] ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: st_nxt = tms_s_r[1] ? TS_EX1_DR : TS_SH_DR;
            TS_SH_DR:  st_nxt = tms_s_r[1] ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: st_nxt = tms_s_r[1] ? TS_UPD_DR : TS_PAU_DR;
            TS_PAU_DR: st_nxt = tms_s_r[1] ? TS_EX2_DR : TS_PAU_DR;
            TS_EX2_DR: st_nxt = tms_s_r[1] ? TS_UPD_DR : TS_SH_DR;
            TS_UPD_DR: st_nxt = tms_s_r[1] ? TS_SEL_DR : TS_IDLE;
            // Select-high path from any state reaches reset in five
            TS_SEL_IR: st_nxt = tms_s_r[1] ? TS_RESET  : TS_CAP_IR;
            TS_CAP_IR: st_nxt = tms_s_r[1] ? TS_EX1_IR : TS_SH_IR;
            TS_SH_IR:  st_nxt = tms_s_r[1] ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: st_nxt = tms_s_r[1] ? TS_UPD_IR : TS_PAU_IR;
            TS_PAU_IR: st_nxt = tms_s_r[1] ? TS_EX2_IR : TS_PAU_IR;
            TS_EX2_IR: st_nxt = tms_s_r[1] ? TS_UPD_IR : TS_SH_IR;
            TS_UPD_IR: st_nxt = tms_s_r[1] ? TS_SEL_DR : TS_IDLE;
            default:   st_nxt = TS_RESET;
         endcase
         case (st_r)
            TS_CAP_DR: begin
               if (ir_r == INS_IDCODE)
                  dr_sh_nxt = id_word;
               else if (sel_bsr)
                  // Pins for sample, core outputs for extest
                  dr_sh_nxt = {{(ID_W-BSR_W){1'b0}}, (ir_r == INS_SAMPLE) ? pin_in : core_out};
               else
                  dr_sh_nxt = '0;
            end
            TS_SH_DR: begin
               // Shift in at selected length, LSB out first
               if (ir_r == INS_IDCODE)
                  dr_sh_nxt = {tdi_s_r[1], dr_sh_r[ID_W-1:1]};
               else if (sel_bsr)
                  dr_sh_nxt = {{(ID_W-BSR_W){1'b0}}, tdi_s_r[1], dr_sh_r[BSR_W-1:1]};
               else
                  dr_sh_nxt = {{(ID_W-1){1'b0}}, tdi_s_r[1]};
            end
            TS_UPD_DR: if (sel_bsr) bsr_out_nxt = dr_sh_r[BSR_W-1:0];
            TS_CAP_IR: ir_sh_nxt = IR_CAPTURE;
            TS_SH_IR:  ir_sh_nxt = {tdi_s_r[1], ir_sh_r[IR_W-1:1]};
            TS_UPD_IR: ir_nxt = ir_sh_r;
            TS_RESET:  ir_nxt = INS_IDCODE;
            default:   ;
         endcase
      end
      // Output bit changes on falling edge
      if (tck_fall) begin
         tdo_nxt = (st_r == TS_SH_IR) ? ir_sh_r[0] : dr_sh_r[0];
      end
      if (trst_act) begin
         st_nxt = TS_RESET;
         ir_nxt = INS_IDCODE;
      end
   end

   // Comes up in reset only via sys reset, not on its own test clock
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r      <= TS_RESET;
         ir_sh_r   <= IR_CAPTURE;
         ir_r      <= INS_IDCODE;
         dr_sh_r   <= '0;
         bsr_out_r <= '0;
         tdo_r     <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         ir_sh_r   <= ir_sh_nxt;
         ir_r      <= ir_nxt;
         dr_sh_r   <= dr_sh_nxt;
         bsr_out_r <= bsr_out_nxt;
         tdo_r     <= tdo_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign tdo     = tdo_r;
   assign tdo_oe  = (st_r == TS_SH_DR) || (st_r == TS_SH_IR);
   assign bsr_out = bsr_out_r;
   // Extest takes the pins away from the buffer
   assign test_ctl     = (ir_r == INS_EXTEST) && (st_r != TS_RESET);
   assign out_hiz      = (ir_r == INS_HIGHZ) && (st_r != TS_RESET);
   // Tells buffer logic the port is reset
   assign tap_in_reset = (st_r == TS_RESET);

endmodule // bsc_tap

// *** tb/bsc_tap_properties.sv ***
// Checker for the test port outputs of bsc_tap.
// Assumes sys_clk oversamples tck, bound below.
`timescale 1ns/1ps
module bsc_tap_properties
   import bsc_pkg::*;
(
   input wire logic             sys_clk,
   input wire logic             rst_b,
   input wire logic             tck,
   input wire logic             tms,
   input wire logic             trst_b,
   input wire logic             tdo,
   input wire logic             tdo_oe,
   input wire logic [BSR_W-1:0] bsr_out,
   input wire logic             test_ctl,
   input wire logic             out_hiz,
   input wire logic             tap_in_reset
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   logic       tck_q;
   logic [2:0] ones_r;
   // Counts tck rises with tms high, saturating
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tck_q  <= 1'b0;
         ones_r <= 3'h0;
      end else begin
         tck_q <= tck;
         if (tck && !tck_q) ones_r <= !tms ? 3'h0 : (ones_r == 3'h5 ? ones_r : ones_r + 3'h1);
      end
   end
   property p_oe_rst; tap_in_reset |-> !tdo_oe; endproperty
   a_oe_rst: assert property (p_oe_rst) else $error("tdo driven in reset");
   property p_trst; (!trst_b)[*5] |-> tap_in_reset; endproperty
   a_trst: assert property (p_trst) else $error("test reset ignored");
   property p_rst_ctl; tap_in_reset |-> !test_ctl && !out_hiz; endproperty
   a_rst_ctl: assert property (p_rst_ctl) else $error("control held in reset");
   property p_excl; test_ctl |-> !out_hiz; endproperty
   a_excl: assert property (p_excl) else $error("two instructions active");
   property p_oe_edge; $changed(tdo_oe) && trst_b |-> $past(tck); endproperty
   a_oe_edge: assert property (p_oe_edge) else $error("state moved off rise");
   property p_tdo_fall; $changed(tdo) |-> !$past(tck); endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off fall");
   property p_bsr_rise; $changed(bsr_out) |-> $past(tck); endproperty
   a_bsr_rise: assert property (p_bsr_rise) else $error("update off rise");
   property p_five; ones_r == 3'h5 |-> ##[0:3] tap_in_reset; endproperty
   a_five: assert property (p_five) else $error("five ones no reset");
endmodule // bsc_tap_properties
bind bsc_tap bsc_tap_properties chk_u (.sys_clk, .rst_b, .tck, .tms, .trst_b, .tdo, .tdo_oe,
   .bsr_out, .test_ctl, .out_hiz, .tap_in_reset);

// *** tb/bsc_host_model.sv ***
// External test controller driving the test pins.
// Assumes the caller enters each task at a sys_clk fall.
`timescale 1ns/1ps
module bsc_host_model (
   input  wire logic sys_clk,
   input  wire logic tdo,
   input  wire logic tdo_oe,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   output logic      trst_b
);
   // Test clock stands low between frames
   initial {tck, tms, tdi, trst_b} = 4'h7;
   // Released line has no pull, so it reads as the inverse
   logic tdo_seen;
   assign tdo_seen = tdo_oe ? tdo : ~tdo;
   // one bit, tms stable around the rise, tdo taken at the rise
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      repeat (4) @(negedge sys_clk);
      q   = tdo_seen;
      tck = 1'b1;
      repeat (4) @(negedge sys_clk);
      tck = 1'b0;
   endtask
   task automatic reset_seq();
      logic q;
      repeat (5) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask
   // test reset held well past the sync stages
   task automatic pulse_trst();
      trst_b = 1'b0;
      repeat (6) @(negedge sys_clk);
      trst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
   endtask
   // scan from Idle, LSB first, back to Idle
   task automatic scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
      logic q;
      dout = '0;
      step(1'b1, 1'b0, q);
      if (ir) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask
endmodule // bsc_host_model

// *** tb/tb_top.sv ***
// Self-checking bench for the boundary-scan port.
// Assumes the host model drives all test pins.
`timescale 1ns/1ps
module tb_top;
   import bsc_pkg::*;
   logic             sys_clk, rst_b, tck, tms, tdi, trst_b, tdo, tdo_oe, q;
   logic [BSR_W-1:0] pin_in, core_out, bsr_out;
   logic             test_ctl, out_hiz, tap_in_reset;
   logic [31:0]      got, dat;
   logic [15:0]      rnd = 16'h0002;
   logic [3:0]       ins [5] = '{INS_SAMPLE, INS_EXTEST, INS_BYPASS, INS_HIGHZ, INS_IDCODE};
   int               err_total = 0;
   int               n_tests = 0;
   bsc_tap dut_u (.sys_clk, .rst_b, .tck, .tms, .tdi, .trst_b, .tdo, .tdo_oe, .pin_in, .core_out,
      .bsr_out, .test_ctl, .out_hiz, .tap_in_reset);
   bsc_host_model host_u (.sys_clk, .tdo, .tdo_oe, .tck, .tms, .tdi, .trst_b);
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Bypass shows its captured zero first
   function automatic logic [7:0] exp_dr(input logic [3:0] op);
      case (op)
         INS_SAMPLE: return pin_in;
         INS_EXTEST: return core_out;
         INS_BYPASS: return {dat[6:0], 1'b0};
         default:    return {ID_MFR[6:0], 1'b1};
      endcase
   endfunction
   task automatic check(input logic [31:0] act, input logic [31:0] exp);
      n_tests++;
      if (act !== exp) begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, act, exp);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge sys_clk);
      err_total++;
      stop_test();
   end
   initial begin
      rst_b = 1'b0;
      pin_in = '0;
      core_out = '0;
      repeat (20) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      host_u.reset_seq();
      check(tdo_oe, 0);
      host_u.scan(1'b0, '0, 32, got);
      check(got, {ID_VERSION, ID_PART, ID_MFR, 1'b1});
      foreach (ins[k]) begin
         rnd = lfsr(rnd);
         {pin_in, core_out} = rnd;
         rnd = lfsr(rnd);
         dat = {16'h0, rnd};
         host_u.scan(1'b1, {28'h0, ins[k]}, 4, got);
         check(got, {28'h0, IR_CAPTURE});
         check(test_ctl, ins[k] == INS_EXTEST);
         check(out_hiz, ins[k] == INS_HIGHZ);
         host_u.scan(1'b0, dat, 8, got);
         if (ins[k] != INS_HIGHZ) check(got[7:0], exp_dr(ins[k]));
         if (ins[k] inside {INS_SAMPLE, INS_EXTEST}) check(bsr_out, dat[7:0]);
      end
      host_u.scan(1'b1, {28'h0, INS_EXTEST}, 4, got);
      repeat (5) host_u.step(1'b1, 1'b0, q);
      check({tap_in_reset, test_ctl}, 2'h2);
      host_u.step(1'b0, 1'b0, q);
      host_u.scan(1'b1, {28'h0, INS_EXTEST}, 4, got);
      host_u.pulse_trst();
      check({tap_in_reset, test_ctl}, 2'h2);
      host_u.step(1'b0, 1'b0, q);
      host_u.scan(1'b0, '0, 32, got);
      check(got, {ID_VERSION, ID_PART, ID_MFR, 1'b1});
      host_u.step(1'b1, 1'b0, q);
      repeat (2) host_u.step(1'b0, 1'b0, q);
      check(tdo_oe, 1);
      repeat (2) host_u.step(1'b1, 1'b0, q);
      host_u.step(1'b0, 1'b0, q);
      check(tdo_oe, 0);
      stop_test();
   end
endmodule // tb_top
